//--- core/ipcis_top.sv
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ipcis_cfg.svh"
// Overview of operation
// R01: Status bits 15..12 are per-slot timeout flags, write one clears.
// R02: Status bits 11..8 read one while the slot fault input is low.
// R03: Status bits 7..0 are request flags, two per slot, A lowest.
// R04: Edge-latched request flag clears on a host write of one or when the slot leaves edge mode.
// R05: Missing acknowledge within 8 us ends access, sets timeout flag.
// R06: Timeout shows only in status; the bus access ends without error.
// R07: A timed out read returns all ones.
// R08: Each module signals requests by pulling one of two lines low.
// R09: Each request input is level or edge sensitive per its setting.
// R10: Host interrupt low while any enabled status flag is set.
// R11: Host interrupt is a plain level line toward the bridge.
// R12: Level request flag follows the line; only the module clears it.
// R13: Software reads the status word before servicing requests.
// R14: Slots sharing a data bus are never driven at the same time.
// R15: Module DMA lines stay inactive high and are never used.
// R16: Control bits 7,6,3,2 enable request1, request0, fault, timeout.
// R17: Control bits 5,4 pick edge (1) or level (0) for requests.
// R18: All per-slot control bits clear to zero at reset.
// R19: Edge requests are synchronised; a falling edge latches the flag.
module ipcis_top #(
  parameter int TIMEOUT_CYC = `IPCIS_TO_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        LNK_CLK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             HOST_INT_N,
  input  wire logic [3:0]  SLOT_REQUEST0_N,
  input  wire logic [3:0]  SLOT_REQUEST1_N,
  input  wire logic [3:0]  SLOT_FAULT_N,
  input  wire logic [3:0]  SLOT_ACKNOWLEDGE_N,
  output logic      [3:0]  SLOT_SELECT_N,
  output logic             SLOT_WRITE_N,
  input  wire logic [15:0] SLOT_AC_DATA_I,
  output logic      [15:0] SLOT_AC_DATA_O,
  output logic             SLOT_AC_DATA_OE,
  input  wire logic [15:0] SLOT_BD_DATA_I,
  output logic      [15:0] SLOT_BD_DATA_O,
  output logic             SLOT_BD_DATA_OE,
  output logic      [3:0]  SLOT_DMA_GRANT_N,
  output logic      [3:0]  SLOT_DMA_FINISH_N
);
  ipcis_xfer_if xf ();

  ipcis_pkg::ipcis_xfer_state_t state_reg;
  logic [1:0]  rst_sync_reg;
  logic [1:0]  lrst_sync_reg;
  logic        rst_n;
  logic        lnk_rst_n;
  logic [7:0]  ctrl_reg [4];
  logic [3:0]  time_reg;
  logic [3:0]  fault_s1_reg;
  logic [3:0]  fault_s2_reg;
  logic [7:0]  req_flag;
  logic [7:0]  req_clr;
  logic [7:0]  req_edge;
  logic [7:0]  req_en;
  logic [7:0]  req_n;
  logic [3:0]  err_en;
  logic [3:0]  to_en;
  logic [15:0] status;
  logic [31:0] prdata_reg;
  logic        irq_n_reg;
  logic        req_reg;
  logic [1:0]  slot_reg;
  logic        write_reg;
  logic [15:0] wdata_reg;
  logic        abort_reg;
  logic [1:0]  done_sync_reg;
  logic        done_seen_reg;
  logic        complete_reg;
  logic [3:0]  to_set;
  logic [7:0]  timer_reg;
  logic        setup;
  logic        access;
  logic        slot_hit;
  logic        reg_wr;
  logic        st_wr;
  logic        done_now;
  logic        launch;
  logic        expired;
  logic [31:0] rd_mux;

  // Reset release, one copy per clock domain
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge LNK_CLK or negedge RST_N)
  begin
    if (!RST_N)
      lrst_sync_reg <= 2'h0;
    else
      lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
  end
  assign lnk_rst_n = lrst_sync_reg[1];

  // APB decode; slot page stalls until the access is finished
  assign setup    = PSEL & ~PENABLE;
  assign access   = PSEL & PENABLE;
  assign slot_hit = (PADDR[7:4] == `IPCIS_SLOT_PAGE);
  assign PREADY   = ~access | ~slot_hit | complete_reg;
  assign PSLVERR  = 1'b0; // R06
  assign PRDATA   = prdata_reg;
  assign reg_wr   = access & PWRITE & ~slot_hit;
  assign st_wr    = reg_wr & (PADDR == `IPCIS_OFS_STATUS);

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int s = 0; s < 4; s++)
        ctrl_reg[s] <= `IPCIS_CTRL_RESET; // R18
    end
    else if (reg_wr && PADDR[7:4] == 4'h0 && PADDR[1:0] == 2'h0)
    begin
      ctrl_reg[PADDR[3:2]] <= PWDATA[7:0] & `IPCIS_CTRL_MASK; // R16 R17
    end
  end

  // Fault lines are live status, synchronised before use
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_s1_reg <= 4'hF;
      fault_s2_reg <= 4'hF;
    end
    else
    begin
      fault_s1_reg <= SLOT_FAULT_N;
      fault_s2_reg <= fault_s1_reg;
    end
  end

  // Timeout flags: event wins over a same-cycle clear
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      time_reg <= 4'h0;
    else if (st_wr)
      time_reg <= (time_reg & ~PWDATA[15:12]) | to_set; // R01
    else
      time_reg <= time_reg | to_set; // R05
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_req
      assign req_n[g]    = ((g % 2) != 0) ? SLOT_REQUEST1_N[g/2] :
                                            SLOT_REQUEST0_N[g/2]; // R08
      assign req_edge[g] = ctrl_reg[g/2][`IPCIS_CTRL_EDGE0 + g%2]; // R17
      assign req_en[g]   = ctrl_reg[g/2][`IPCIS_CTRL_EN0 + g%2]; // R16
      assign req_clr[g]  = st_wr & PWDATA[g]; // R04
      ipcis_req_cond u_cond (
        .clk      (CLK_SYS),
        .rst_n    (rst_n),
        .req_n    (req_n[g]),
        .edge_sel (req_edge[g]),
        .clr      (req_clr[g]),
        .flag     (req_flag[g])
      );
    end
    for (g = 0; g < 4; g++)
    begin : g_slot
      assign err_en[g] = ctrl_reg[g][`IPCIS_CTRL_ERR_EN]; // R16
      assign to_en[g]  = ctrl_reg[g][`IPCIS_CTRL_TO_EN]; // R16
    end
  endgenerate

  assign status = {time_reg, ~fault_s2_reg, req_flag}; // R01 R02 R03

  // Registered so the host line never glitches
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      irq_n_reg <= 1'b1;
    else
      irq_n_reg <= ~(|(req_flag & req_en) | |(~fault_s2_reg & err_en) |
                     |(time_reg & to_en)); // R10
  end
  assign HOST_INT_N = irq_n_reg; // R11

  // Register read data captured in the setup cycle
  always_comb
  begin
    rd_mux = 32'h0;
    if (PADDR == `IPCIS_OFS_STATUS)
      rd_mux = {16'h0, status}; // R03
    else if (PADDR[7:4] == 4'h0 && PADDR[1:0] == 2'h0)
      rd_mux = {24'h0, ctrl_reg[PADDR[3:2]]};
  end

  // Slot access sequencer toward the link domain
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      done_sync_reg <= 2'h0;
    else
      done_sync_reg <= {done_sync_reg[0], xf.done_tgl};
  end

  assign done_now = (done_sync_reg[1] != done_seen_reg);
  assign launch   = access & slot_hit & ~complete_reg &
                    (state_reg == ipcis_pkg::XF_IDLE);
  assign expired  = (timer_reg == 8'(TIMEOUT_CYC - 1));
  assign to_set   = (state_reg == ipcis_pkg::XF_WAIT && !done_now &&
                     expired) ? (4'h1 << slot_reg) : 4'h0; // R05

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= ipcis_pkg::XF_IDLE;
      req_reg       <= 1'b0;
      slot_reg      <= 2'h0;
      write_reg     <= 1'b0;
      wdata_reg     <= 16'h0;
      abort_reg     <= 1'b0;
      done_seen_reg <= 1'b0;
      complete_reg  <= 1'b0;
      timer_reg     <= 8'h0;
      prdata_reg    <= 32'h0;
    end
    else
    begin
      if (setup && !slot_hit)
        prdata_reg <= rd_mux;
      if (access && PREADY)
        complete_reg <= 1'b0;
      case (state_reg)
        ipcis_pkg::XF_IDLE:
        begin
          if (launch)
          begin
            slot_reg  <= PADDR[3:2];
            write_reg <= PWRITE;
            wdata_reg <= PWDATA[15:0];
            req_reg   <= ~req_reg;
            timer_reg <= 8'h0;
            state_reg <= ipcis_pkg::XF_WAIT;
          end
        end
        ipcis_pkg::XF_WAIT:
        begin
          timer_reg <= timer_reg + 8'h1;
          if (done_now)
          begin
            done_seen_reg <= done_sync_reg[1];
            prdata_reg    <= {16'h0, xf.rdata};
            complete_reg  <= 1'b1;
            state_reg     <= ipcis_pkg::XF_IDLE;
          end
          else if (expired)
          begin
            // Host access ends normally; link is told to let go
            prdata_reg   <= {16'h0, `IPCIS_RD_TIMEOUT}; // R07
            complete_reg <= 1'b1; // R06
            abort_reg    <= 1'b1; // R05
            state_reg    <= ipcis_pkg::XF_DRAIN;
          end
        end
        ipcis_pkg::XF_DRAIN:
        begin
          if (done_now)
          begin
            done_seen_reg <= done_sync_reg[1];
            abort_reg     <= 1'b0;
            state_reg     <= ipcis_pkg::XF_IDLE;
          end
        end
        default:
          state_reg <= ipcis_pkg::XF_IDLE;
      endcase
    end
  end

  assign xf.req_tgl = req_reg;
  assign xf.slot    = slot_reg;
  assign xf.write   = write_reg;
  assign xf.wdata   = wdata_reg;
  assign xf.abort   = abort_reg;

  ipcis_slot_link u_link (
    .lnk_clk   (LNK_CLK),
    .lnk_rst_n (lnk_rst_n),
    .xf        (xf),
    .ack_n     (SLOT_ACKNOWLEDGE_N),
    .sel_n     (SLOT_SELECT_N),
    .write_n   (SLOT_WRITE_N),
    .ac_i      (SLOT_AC_DATA_I),
    .ac_o      (SLOT_AC_DATA_O),
    .ac_oe     (SLOT_AC_DATA_OE),
    .bd_i      (SLOT_BD_DATA_I),
    .bd_o      (SLOT_BD_DATA_O),
    .bd_oe     (SLOT_BD_DATA_OE)
  );

  // No module DMA on this carrier
  assign SLOT_DMA_GRANT_N  = 4'hF; // R15
  assign SLOT_DMA_FINISH_N = 4'hF; // R15
endmodule : ipcis_top

//--- core/ipcis_cfg.svh
`ifndef IPCIS_CFG_SVH
`define IPCIS_CFG_SVH

// Register byte offsets
`define IPCIS_OFS_CTRL_A   8'h00
`define IPCIS_OFS_CTRL_B   8'h04
`define IPCIS_OFS_CTRL_C   8'h08
`define IPCIS_OFS_CTRL_D   8'h0C
`define IPCIS_OFS_STATUS   8'h10
`define IPCIS_SLOT_PAGE    4'h2

// Control field positions
`define IPCIS_CTRL_TO_EN   2
`define IPCIS_CTRL_ERR_EN  3
`define IPCIS_CTRL_EDGE0   4
`define IPCIS_CTRL_EDGE1   5
`define IPCIS_CTRL_EN0     6
`define IPCIS_CTRL_EN1     7
`define IPCIS_CTRL_MASK    8'hFC
`define IPCIS_CTRL_RESET   8'h00

// Status field positions
`define IPCIS_ST_TIME_LO   12
`define IPCIS_ST_ERR_LO    8
`define IPCIS_ST_REQ_LO    0

// Timing
`define IPCIS_TO_NS        8000
`define IPCIS_SYS_NS       100
`define IPCIS_TO_CYC       (`IPCIS_TO_NS / `IPCIS_SYS_NS)
`define IPCIS_RD_TIMEOUT   16'hFFFF

`endif

//--- core/ipcis_pkg.sv
package ipcis_pkg;

  typedef enum logic [2:0] {
    XF_IDLE  = 3'b001,
    XF_WAIT  = 3'b010,
    XF_DRAIN = 3'b100
  } ipcis_xfer_state_t;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b01,
    LK_RUN  = 2'b10
  } ipcis_link_state_t;

  typedef logic [1:0]  ipcis_slot_t;
  typedef logic [15:0] ipcis_word_t;

endpackage : ipcis_pkg

//--- core/ipcis_xfer_if.sv
`timescale 1ns/1ps
interface ipcis_xfer_if;
  logic                 req_tgl;
  ipcis_pkg::ipcis_slot_t slot;
  logic                 write;
  ipcis_pkg::ipcis_word_t wdata;
  logic                 abort;
  logic                 done_tgl;
  ipcis_pkg::ipcis_word_t rdata;

  modport sys (output req_tgl, output slot, output write, output wdata,
               output abort, input done_tgl, input rdata);
  modport lnk (input req_tgl, input slot, input write, input wdata,
               input abort, output done_tgl, output rdata);
endinterface : ipcis_xfer_if

//--- core/ipcis_req_cond.sv
`timescale 1ns/1ps
module ipcis_req_cond (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic req_n,
  input  wire logic edge_sel,
  input  wire logic clr,
  output logic      flag
);
  logic s1_reg;
  logic s2_reg;
  logic prev_reg;
  logic latch_reg;
  logic fall;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg   <= 1'b1;
      s2_reg   <= 1'b1;
      prev_reg <= 1'b1;
    end
    else
    begin
      s1_reg   <= req_n; // R19
      s2_reg   <= s1_reg;
      prev_reg <= s2_reg;
    end
  end

  assign fall = prev_reg & ~s2_reg; // R19

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      latch_reg <= 1'b0;
    else if (!edge_sel)
      latch_reg <= 1'b0;
    else
      latch_reg <= (latch_reg & ~clr) | fall; // R04
  end

  // Level mode just mirrors the line; host writes cannot touch it
  assign flag = edge_sel ? latch_reg : ~s2_reg; // R09
endmodule : ipcis_req_cond

//--- core/ipcis_slot_link.sv
`timescale 1ns/1ps
module ipcis_slot_link (
  input  wire logic        lnk_clk,
  input  wire logic        lnk_rst_n,
  ipcis_xfer_if.lnk        xf,
  input  wire logic [3:0]  ack_n,
  output logic      [3:0]  sel_n,
  output logic             write_n,
  input  wire logic [15:0] ac_i,
  output logic      [15:0] ac_o,
  output logic             ac_oe,
  input  wire logic [15:0] bd_i,
  output logic      [15:0] bd_o,
  output logic             bd_oe
);
  ipcis_pkg::ipcis_link_state_t state_reg;
  logic [1:0]  req_sync_reg;
  logic [1:0]  abort_sync_reg;
  logic [3:0]  ack_s1_reg;
  logic [3:0]  ack_s2_reg;
  logic [31:0] dat_s1_reg;
  logic [31:0] dat_s2_reg;
  logic        req_seen_reg;
  logic        done_reg;
  logic [15:0] rdata_reg;
  logic        pending;
  logic        acked;

  always_ff @(posedge lnk_clk or negedge lnk_rst_n)
  begin
    if (!lnk_rst_n)
    begin
      req_sync_reg   <= 2'h0;
      abort_sync_reg <= 2'h0;
      ack_s1_reg     <= 4'hF;
      ack_s2_reg     <= 4'hF;
      dat_s1_reg     <= 32'h0;
      dat_s2_reg     <= 32'h0;
    end
    else
    begin
      req_sync_reg   <= {req_sync_reg[0], xf.req_tgl};
      abort_sync_reg <= {abort_sync_reg[0], xf.abort};
      ack_s1_reg     <= ack_n;
      ack_s2_reg     <= ack_s1_reg;
      dat_s1_reg     <= {bd_i, ac_i};
      dat_s2_reg     <= dat_s1_reg;
    end
  end

  // Stale abort from the last cycle must be gone before a new start
  assign pending = (req_sync_reg[1] != req_seen_reg) & ~abort_sync_reg[1];
  assign acked   = ~ack_s2_reg[xf.slot];

  always_ff @(posedge lnk_clk or negedge lnk_rst_n)
  begin
    if (!lnk_rst_n)
    begin
      state_reg    <= ipcis_pkg::LK_IDLE;
      sel_n        <= 4'hF;
      write_n      <= 1'b1;
      ac_o         <= 16'h0;
      bd_o         <= 16'h0;
      ac_oe        <= 1'b0;
      bd_oe        <= 1'b0;
      req_seen_reg <= 1'b0;
      done_reg     <= 1'b0;
      rdata_reg    <= 16'h0;
    end
    else
    begin
      case (state_reg)
        ipcis_pkg::LK_IDLE:
        begin
          if (pending)
          begin
            // One slot and at most one pair bus driven at any time
            sel_n            <= 4'hF;
            sel_n[xf.slot]   <= 1'b0; // R14
            write_n          <= ~xf.write;
            ac_o             <= xf.wdata;
            bd_o             <= xf.wdata;
            ac_oe            <= xf.write & ~xf.slot[0]; // R14
            bd_oe            <= xf.write & xf.slot[0]; // R14
            state_reg        <= ipcis_pkg::LK_RUN;
          end
        end
        ipcis_pkg::LK_RUN:
        begin
          if (acked | abort_sync_reg[1])
          begin
            rdata_reg    <= abort_sync_reg[1] ? `IPCIS_RD_TIMEOUT :
                            (xf.slot[0] ? dat_s2_reg[31:16] :
                                          dat_s2_reg[15:0]);
            sel_n        <= 4'hF;
            write_n      <= 1'b1;
            ac_oe        <= 1'b0;
            bd_oe        <= 1'b0;
            req_seen_reg <= req_sync_reg[1];
            done_reg     <= ~done_reg;
            state_reg    <= ipcis_pkg::LK_IDLE;
          end
        end
        default:
          state_reg <= ipcis_pkg::LK_IDLE;
      endcase
    end
  end

  assign xf.done_tgl = done_reg;
  assign xf.rdata    = rdata_reg;
endmodule : ipcis_slot_link

//--- sim/ipcis_chk.sv
`timescale 1ns/1ps
module ipcis_chk #(
  parameter int TIMEOUT_CYC = 80
) (
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic        LNK_CLK,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        HOST_INT_N,
  input wire logic [3:0]  SLOT_ACKNOWLEDGE_N,
  input wire logic [3:0]  SLOT_SELECT_N,
  input wire logic        SLOT_AC_DATA_OE,
  input wire logic        SLOT_BD_DATA_OE,
  input wire logic [3:0]  SLOT_DMA_GRANT_N,
  input wire logic [3:0]  SLOT_DMA_FINISH_N
);
  localparam int WMAX = TIMEOUT_CYC + 40;
  // Link runs faster, so a stuck select gets twice the budget
  localparam int SMAX = 2 * TIMEOUT_CYC + 20;
  logic       acc;
  logic [8:0] wait_cnt;
  logic [8:0] sel_cnt;
  assign acc = PSEL && PENABLE && PADDR[5];
  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N) wait_cnt <= '0;
    else if (acc && !PREADY) wait_cnt <= wait_cnt + 9'h001;
    else wait_cnt <= '0;
  always_ff @(posedge LNK_CLK or negedge RST_N)
    if (!RST_N) sel_cnt <= '0;
    else if (SLOT_SELECT_N != 4'hF) sel_cnt <= sel_cnt + 9'h001;
    else sel_cnt <= '0;
  AST_NO_SLVERR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    PSLVERR == 1'b0) else $error("slave error raised");
  AST_DMA_IDLE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (SLOT_DMA_GRANT_N & SLOT_DMA_FINISH_N) == 4'hF)
    else $error("dma line active");
  AST_REG_NO_WAIT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    PSEL && PENABLE && !PADDR[5] |-> PREADY) else $error("register wait");
  AST_SLOT_BOUND: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wait_cnt <= WMAX) else $error("slot access never ends");
  AST_TMO_DATA: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    acc && PREADY && !PWRITE && wait_cnt >= TIMEOUT_CYC
    |-> PRDATA == 32'h0000FFFF) else $error("timed out read data");
  AST_ONE_SELECT: assert property (@(posedge LNK_CLK) disable iff (!RST_N)
    $onehot0(~SLOT_SELECT_N)) else $error("two slots selected");
  AST_ONE_BUS: assert property (@(posedge LNK_CLK) disable iff (!RST_N)
    !(SLOT_AC_DATA_OE && SLOT_BD_DATA_OE)) else $error("both buses driven");
  AST_ACK_ENDS: assert property (@(posedge LNK_CLK) disable iff (!RST_N)
    (~SLOT_ACKNOWLEDGE_N & ~SLOT_SELECT_N) != 4'h0
    |-> ##[1:5] SLOT_SELECT_N == 4'hF) else $error("select held after ack");
  AST_SEL_BOUND: assert property (@(posedge LNK_CLK) disable iff (!RST_N)
    sel_cnt <= SMAX) else $error("select never released");
  COV_TMO: cover property (@(posedge CLK_SYS) acc && PREADY
    && wait_cnt >= TIMEOUT_CYC);
  COV_INT: cover property (@(posedge CLK_SYS) !HOST_INT_N);
  COV_AC: cover property (@(posedge LNK_CLK) SLOT_AC_DATA_OE);
  COV_BD: cover property (@(posedge LNK_CLK) SLOT_BD_DATA_OE);
endmodule : ipcis_chk

//--- sim/ipcis_slot_mdl.sv
`timescale 1ns/1ps
module ipcis_slot_mdl (
  input  wire logic        lnk_clk,
  input  wire logic [3:0]  sel_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] ac_o,
  input  wire logic        ac_oe,
  input  wire logic [15:0] bd_o,
  input  wire logic        bd_oe,
  input  wire logic [3:0]  mute,
  input  wire logic [3:0]  slow,
  input  wire logic [7:0]  irq,
  output logic      [3:0]  ack_n,
  output logic      [15:0] ac_i,
  output logic      [15:0] bd_i,
  output logic      [3:0]  req0_n,
  output logic      [3:0]  req1_n
);
  logic [15:0] mem [4];
  logic [15:0] junk = 16'h5A5A;
  int          cnt  = 0;
  initial ack_n = 4'hF;
  always_comb
    for (int k = 0; k < 4; k++)
    begin
      req0_n[k] = ~irq[2*k];
      req1_n[k] = ~irq[2*k+1];
    end
  // Released bus toggles so a stale value is never mistaken for data
  assign ac_i = ac_oe ? ac_o : (!sel_n[0] && !mute[0]) ? mem[0] :
                (!sel_n[2] && !mute[2]) ? mem[2] : junk;
  assign bd_i = bd_oe ? bd_o : (!sel_n[1] && !mute[1]) ? mem[1] :
                (!sel_n[3] && !mute[3]) ? mem[3] : ~junk;
  always @(posedge lnk_clk)
  begin
    junk <= ~junk;
    if (sel_n == 4'hF)
    begin
      ack_n <= 4'hF;
      cnt <= 0;
    end
    else
      for (int k = 0; k < 4; k++)
        if (!sel_n[k] && !mute[k])
        begin
          cnt <= cnt + 1;
          if (cnt >= (slow[k] ? 10 : 1))
          begin
            ack_n[k] <= 1'b0;
            if (!wr_n) mem[k] <= k[0] ? bd_o : ac_o;
          end
        end
  end
endmodule : ipcis_slot_mdl

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic        CLK_SYS = 0, LNK_CLK = 0, RST_N = 0;
  logic        PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000, PRDATA, rd, r;
  logic        PREADY, PSLVERR, HOST_INT_N, SLOT_WRITE_N;
  logic [3:0]  SLOT_REQUEST0_N, SLOT_REQUEST1_N, SLOT_FAULT_N = 4'hF;
  logic [3:0]  SLOT_ACKNOWLEDGE_N, SLOT_SELECT_N;
  logic [3:0]  SLOT_DMA_GRANT_N, SLOT_DMA_FINISH_N, mute = 0, slow = 0;
  logic [15:0] SLOT_AC_DATA_I, SLOT_AC_DATA_O, SLOT_BD_DATA_I;
  logic [15:0] SLOT_BD_DATA_O;
  logic        SLOT_AC_DATA_OE, SLOT_BD_DATA_OE;
  logic [7:0]  irq = 0, m_edge = 0, m_ctrl [4] = '{4{8'h00}};
  logic [3:0]  m_tmo = 0;
  logic [31:0] seed = 32'h00000026;
  int          n_errors = 0, compares = 0, cyc = 0;
  ipcis_top #(.TIMEOUT_CYC(40)) i_ipcis_top (.CLK_SYS, .RST_N, .LNK_CLK,
    .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .HOST_INT_N, .SLOT_REQUEST0_N, .SLOT_REQUEST1_N, .SLOT_FAULT_N,
    .SLOT_ACKNOWLEDGE_N, .SLOT_SELECT_N, .SLOT_WRITE_N, .SLOT_AC_DATA_I,
    .SLOT_AC_DATA_O, .SLOT_AC_DATA_OE, .SLOT_BD_DATA_I, .SLOT_BD_DATA_O,
    .SLOT_BD_DATA_OE, .SLOT_DMA_GRANT_N, .SLOT_DMA_FINISH_N);
  ipcis_slot_mdl i_ipcis_slot_mdl (.lnk_clk(LNK_CLK), .sel_n(SLOT_SELECT_N),
    .wr_n(SLOT_WRITE_N), .ac_o(SLOT_AC_DATA_O), .ac_oe(SLOT_AC_DATA_OE),
    .bd_o(SLOT_BD_DATA_O), .bd_oe(SLOT_BD_DATA_OE), .mute, .slow, .irq,
    .ack_n(SLOT_ACKNOWLEDGE_N), .ac_i(SLOT_AC_DATA_I),
    .bd_i(SLOT_BD_DATA_I), .req0_n(SLOT_REQUEST0_N),
    .req1_n(SLOT_REQUEST1_N));
  always #50 CLK_SYS = ~CLK_SYS;
  always
  begin
    #7;
    forever #32 LNK_CLK = ~LNK_CLK;
  end
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function logic [15:0] exp_st();
    logic [7:0] q;
    for (int i = 0; i < 8; i++)
      q[i] = m_ctrl[i/2][4+i%2] ? m_edge[i] : irq[i];
    return {m_tmo, ~SLOT_FAULT_N, q};
  endfunction : exp_st
  function logic exp_int(logic [15:0] s);
    logic [15:0] en;
    for (int k = 0; k < 4; k++)
      {en[12+k], en[8+k], en[2*k+1], en[2*k]} =
        {m_ctrl[k][2], m_ctrl[k][3], m_ctrl[k][7], m_ctrl[k][6]};
    return !(|(s & en));
  endfunction : exp_int
  task report_and_stop();
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1) @(posedge CLK_SYS);
    rd = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task wr_ctrl(logic [1:0] s, logic [7:0] v);
    apb(1'b1, {4'h0, s, 2'b00}, {24'h000000, v});
    m_ctrl[s] = v & 8'hFC;
    // Leaving edge mode drops the latched flag
    for (int b = 0; b < 2; b++)
      if (!m_ctrl[s][4+b]) m_edge[2*s+b] = 1'b0;
  endtask : wr_ctrl
  task wr_st(logic [15:0] v);
    apb(1'b1, 8'h10, {16'h0000, v});
    m_tmo &= ~v[15:12];
    m_edge &= ~v[7:0];
  endtask : wr_st
  task set_irq(logic [7:0] v);
    for (int i = 0; i < 8; i++)
      if (v[i] && !irq[i] && m_ctrl[i/2][4+i%2]) m_edge[i] = 1'b1;
    irq <= v;
  endtask : set_irq
  task check_all();
    repeat (6) @(posedge CLK_SYS);
    apb(1'b0, 8'h10, 32'h00000000);
    chk("status", {16'h0000, exp_st()}, rd);
    chk("host_int", {31'h0, exp_int(exp_st())}, {31'h0, HOST_INT_N});
  endtask : check_all
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (8) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b0, 8'(s * 4), 32'h00000000);
      chk("ctrl_reset", 32'h00000000, rd);
    end
    check_all();
    apb(1'b1, 8'h14, 32'hFFFFFFFF);
    apb(1'b0, 8'h14, 32'h00000000);
    chk("unmapped", 32'h00000000, rd);
    for (int s = 0; s < 4; s++)
    begin
      r = xs();
      wr_ctrl(2'(s), r[7:0]);
      apb(1'b0, 8'(s * 4), 32'h00000000);
      chk("ctrl", {24'h000000, m_ctrl[s]}, rd);
      wr_ctrl(2'(s), 8'h00);
    end
    r = xs();
    SLOT_FAULT_N <= r[3:0];
    set_irq(r[15:8]);
    check_all();
    wr_st(16'h0FFF);
    check_all();
    for (int s = 0; s < 4; s++) wr_ctrl(2'(s), 8'hCC);
    check_all();
    SLOT_FAULT_N <= 4'hF;
    set_irq(8'h00);
    check_all();
    for (int s = 0; s < 4; s++) wr_ctrl(2'(s), 8'hFC);
    for (int k = 0; k < 3; k++)
    begin
      r = xs();
      set_irq(r[7:0]);
      repeat (6) @(posedge CLK_SYS);
      set_irq(8'h00);
      check_all();
      wr_st(16'h0000);
      check_all();
      wr_st({8'h00, r[15:8]});
      check_all();
      wr_st(16'h00FF);
    end
    slow <= 4'b1010;
    for (int s = 0; s < 4; s++)
    begin
      r = xs();
      apb(1'b1, 8'(8'h20 + s * 4), {16'h0000, r[15:0]});
      apb(1'b0, 8'(8'h20 + s * 4), 32'h00000000);
      chk("slot_data", {16'h0000, r[15:0]}, rd);
    end
    mute <= 4'h4;
    apb(1'b0, 8'h28, 32'h00000000);
    chk("timeout_data", 32'h0000FFFF, rd);
    m_tmo[2] = 1'b1;
    repeat (30) @(posedge CLK_SYS);
    check_all();
    mute <= 4'h1;
    apb(1'b1, 8'h20, 32'h00001234);
    m_tmo[0] = 1'b1;
    repeat (30) @(posedge CLK_SYS);
    check_all();
    wr_st(16'h0000);
    check_all();
    wr_st(16'h4000);
    check_all();
    wr_st(16'h1000);
    check_all();
    mute <= 4'h0;
    apb(1'b1, 8'h24, 32'h0000A5C3);
    apb(1'b0, 8'h24, 32'h00000000);
    chk("slot_after", 32'h0000A5C3, rd);
    report_and_stop();
  end
endmodule : tb
bind ipcis_top ipcis_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.CLK_SYS, .RST_N,
  .LNK_CLK, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
  .HOST_INT_N, .SLOT_ACKNOWLEDGE_N, .SLOT_SELECT_N, .SLOT_AC_DATA_OE,
  .SLOT_BD_DATA_OE, .SLOT_DMA_GRANT_N, .SLOT_DMA_FINISH_N);
